// ===== hdl/sync_proc_pkg.sv
// constants shared by the monitor sync processor control block
// assumes a 40 MHz system clock and a 32-bit classic wishbone slave port
package sync_proc_pkg;

    // =====================================================================
    // clock and bus
    // =====================================================================
    localparam longint CLK_HZ = 40_000_000;
    localparam int ADR_W = 10;
    localparam int DAT_W = 32;

    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_CTRL2 = 8'hef;
    localparam logic [7:0] IDX_READBACK = 8'hf0;
    localparam logic [7:0] IDX_MODE = 8'hf1;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hf2;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hf3;

    // =====================================================================
    // sync_ctrl_2 fields
    // =====================================================================
    localparam int CTRL2_UNMIXED = 7;
    localparam int CTRL2_UNUSED = 6;
    localparam int CTRL2_CLKSEL = 5;
    localparam int CTRL2_PSEUDO_OFF = 4;
    localparam int CTRL2_OUT_OFF = 3;
    localparam int CTRL2_SOG = 2;
    localparam int CTRL2_LATCH_CHG = 1;
    localparam int CTRL2_LEVEL = 0;
    localparam logic [7:0] CTRL2_RESET = 8'h00;

    // sync_pin_readback fields
    localparam int RB_VOUT = 3;
    localparam int RB_HOUT = 2;
    localparam int RB_VIN = 1;
    localparam int RB_HIN = 0;

    // mode register: vertical_output_select and counter view
    localparam int MODE_VOS = 0;
    localparam int MODE_CNT_LSB = 8;
    localparam logic MODE_VOS_RESET = 1'b0;

    // interrupt status and mask layout
    localparam int IRQ_W = 3;
    localparam int IRQ_LATCH = 0;
    localparam int IRQ_SOG = 1;
    localparam int IRQ_VRISE = 2;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // =====================================================================
    // counters and timing
    // =====================================================================
    localparam logic [1:0] DIV_BY3_LAST = 2'h2;
    localparam logic [1:0] DIV_BY2_LAST = 2'h1;
    localparam logic [4:0] CNT_FULL = 5'h1f;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam longint MAX_HPULSE_PS = 7_850_000;
    localparam longint REF_SAMPLE_HZ = 4_000_000;
    localparam longint MAX_HPULSE_SAMPLES = MAX_HPULSE_PS * REF_SAMPLE_HZ / 64'd1_000_000_000_000;
    localparam int SOG_EDGES = 64;
    localparam logic [5:0] SOG_CNT_LAST = 6'(SOG_EDGES - 1);

    localparam longint PSEUDO_H_PERIOD_NS = 31_750;
    localparam longint PSEUDO_H_WIDTH_NS = 3_800;
    localparam logic [10:0] PSEUDO_H_PERIOD_CYC = 11'(PSEUDO_H_PERIOD_NS * CLK_HZ / 1_000_000_000);
    localparam logic [10:0] PSEUDO_H_WIDTH_CYC =
        11'((PSEUDO_H_WIDTH_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
    localparam logic [9:0] PSEUDO_V_LINES = 10'h20d;
    localparam logic [9:0] PSEUDO_V_WIDTH_LINES = 10'h002;

endpackage

// ===== hdl/monitor_sync_processor_control.sv
// control and status logic of the monitor sync processor
// assumes async sync pins, one 40 MHz clock and a classic wishbone master
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
module monitor_sync_processor_control
    import sync_proc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [DAT_W-1:0] dat_i,
    output logic [DAT_W-1:0] dat_o,
    output logic ack_o,
    input wire logic hsyncIn,
    input wire logic vsyncIn,
    input wire logic csyncIn,
    output logic hsyncOut,
    output logic vsyncOut,
    output logic levelSel3v3,
    output logic irq
);

    // =====================================================================
    // pin synchronizers
    // =====================================================================
    logic [2:0] pinMeta;
    logic [2:0] pinSync;
    logic hsyncS;
    logic vsyncS;
    logic csyncS;
    logic csyncD;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= 3'h0;
            pinSync <= 3'h0;
        end else begin
            pinMeta <= {csyncIn, vsyncIn, hsyncIn};
            pinSync <= pinMeta;
        end
    end

    assign hsyncS = pinSync[0];
    assign vsyncS = pinSync[1];
    assign csyncS = pinSync[2];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            csyncD <= 1'b0;
        end else begin
            csyncD <= csyncS;
        end
    end

    // =====================================================================
    // bus decode
    // =====================================================================
    logic [7:0] ctrl2;
    logic vertical_output_select;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [7:0] regIdx;
    logic busReq;
    logic wrCommit;
    logic wrLane0;

    assign regIdx = adr_i[ADR_W-1:2];
    assign busReq = cyc_i && stb_i;
    // write lands on the edge where the master samples ack
    assign wrCommit = busReq && we_i && ack_o;
    assign wrLane0 = wrCommit && sel_i[0];

    // =====================================================================
    // sample clock divider
    // =====================================================================
    logic [1:0] divCnt;
    logic tick;
    logic [1:0] divLast;

    assign divLast = ctrl2[CTRL2_CLKSEL] ? DIV_BY2_LAST : DIV_BY3_LAST;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            divCnt <= 2'h0;
            tick <= 1'b0;
        end else if (divCnt >= divLast) begin
            divCnt <= 2'h0;
            tick <= 1'b1;
        end else begin
            divCnt <= divCnt + 2'h1;
            tick <= 1'b0;
        end
    end

    // =====================================================================
    // up/down counter and separated sync latch
    // =====================================================================
    // 31 samples at 40 MHz / 3 or 40 MHz / 2 is the widest pulse the counter can span
    logic [4:0] udCnt;
    logic sepVsync;
    logic latchChange;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            udCnt <= CNT_ZERO;
        end else if (tick) begin
            if (csyncS && udCnt != CNT_FULL) begin
                udCnt <= udCnt + 5'h01;
            end else if (!csyncS && udCnt != CNT_ZERO) begin
                udCnt <= udCnt - 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sepVsync <= 1'b0;
        end else if (udCnt == CNT_FULL) begin
            sepVsync <= 1'b1;
        end else if (udCnt == CNT_ZERO) begin
            sepVsync <= 1'b0;
        end
    end

    logic sepVsyncD;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sepVsyncD <= 1'b0;
        end else begin
            sepVsyncD <= sepVsync;
        end
    end
    assign latchChange = sepVsync != sepVsyncD;

    // =====================================================================
    // mixed / unmixed horizontal period
    // =====================================================================
    logic unmixed;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            unmixed <= 1'b0;
        end else if (!vertical_output_select || sepVsync) begin
            unmixed <= 1'b0;
        end else if (csyncD && !csyncS) begin
            unmixed <= 1'b1;
        end
    end

    // =====================================================================
    // sync-on-green edge counter
    // =====================================================================
    logic [5:0] sogCnt;
    logic sogEdge;
    logic sogFound;
    logic sogClear;

    assign sogEdge = csyncS != csyncD;
    assign sogClear = wrLane0 && regIdx == IDX_CTRL2 && !dat_i[CTRL2_SOG];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sogCnt <= 6'h00;
        end else if (sogClear) begin
            sogCnt <= 6'h00;
        end else if (sogEdge && !sogFound) begin
            sogCnt <= sogCnt + 6'h01;
        end
    end
    // the sixty-fourth edge decides presence
    assign sogFound = ctrl2[CTRL2_SOG];

    // =====================================================================
    // sync_ctrl_2
    // =====================================================================
    logic sogSet;
    assign sogSet = sogEdge && !sogFound && sogCnt == SOG_CNT_LAST;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl2 <= CTRL2_RESET;
        end else begin
            if (wrLane0 && regIdx == IDX_CTRL2) begin
                ctrl2[CTRL2_CLKSEL] <= dat_i[CTRL2_CLKSEL];
                ctrl2[CTRL2_PSEUDO_OFF] <= dat_i[CTRL2_PSEUDO_OFF];
                ctrl2[CTRL2_OUT_OFF] <= dat_i[CTRL2_OUT_OFF];
                ctrl2[CTRL2_LEVEL] <= dat_i[CTRL2_LEVEL];
                if (!dat_i[CTRL2_SOG]) begin
                    ctrl2[CTRL2_SOG] <= 1'b0;
                end
                if (!dat_i[CTRL2_LATCH_CHG]) begin
                    ctrl2[CTRL2_LATCH_CHG] <= 1'b0;
                end
            end
            // hardware sets win over a clearing write
            if (sogSet) begin
                ctrl2[CTRL2_SOG] <= 1'b1;
            end
            if (latchChange) begin
                ctrl2[CTRL2_LATCH_CHG] <= 1'b1;
            end
            ctrl2[CTRL2_UNMIXED] <= unmixed;
            ctrl2[CTRL2_UNUSED] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            vertical_output_select <= MODE_VOS_RESET;
        end else if (wrLane0 && regIdx == IDX_MODE) begin
            vertical_output_select <= dat_i[MODE_VOS];
        end
    end

    // =====================================================================
    // pseudo sync generator
    // =====================================================================
    // free running so a monitor with no input still gets a valid raster
    logic [10:0] pHCnt;
    logic [9:0] pLine;
    logic pseudoH;
    logic pseudoV;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pHCnt <= 11'h000;
            pLine <= 10'h000;
        end else if (pHCnt == PSEUDO_H_PERIOD_CYC - 11'h001) begin
            pHCnt <= 11'h000;
            pLine <= (pLine == PSEUDO_V_LINES - 10'h001) ? 10'h000 : pLine + 10'h001;
        end else begin
            pHCnt <= pHCnt + 11'h001;
        end
    end
    assign pseudoH = pHCnt < PSEUDO_H_WIDTH_CYC;
    assign pseudoV = pLine < PSEUDO_V_WIDTH_LINES;

    // =====================================================================
    // sync outputs and level select
    // =====================================================================
    logic next_hsyncOut;
    logic next_vsyncOut;

    always_comb begin
        if (ctrl2[CTRL2_OUT_OFF]) begin
            next_hsyncOut = 1'b0;
            next_vsyncOut = 1'b0;
        end else if (!ctrl2[CTRL2_PSEUDO_OFF]) begin
            next_hsyncOut = pseudoH;
            next_vsyncOut = pseudoV;
        end else begin
            next_hsyncOut = vertical_output_select ? csyncS : hsyncS;
            next_vsyncOut = vertical_output_select ? sepVsync : vsyncS;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hsyncOut <= 1'b0;
            vsyncOut <= 1'b0;
            levelSel3v3 <= 1'b0;
        end else begin
            hsyncOut <= next_hsyncOut;
            vsyncOut <= next_vsyncOut;
            levelSel3v3 <= ctrl2[CTRL2_LEVEL];
        end
    end

    // =====================================================================
    // interrupts
    // =====================================================================
    logic [IRQ_W-1:0] irqEvent;
    assign irqEvent = {sepVsync && !sepVsyncD, sogSet, latchChange};

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irqStat <= IRQ_RESET;
            irqMask <= IRQ_RESET;
            irq <= 1'b0;
        end else begin
            if (wrLane0 && regIdx == IDX_IRQ_MASK) begin
                irqMask <= dat_i[IRQ_W-1:0];
            end
            if (wrLane0 && regIdx == IDX_IRQ_STAT) begin
                irqStat <= (irqStat & ~dat_i[IRQ_W-1:0]) | irqEvent;
            end else begin
                irqStat <= irqStat | irqEvent;
            end
            irq <= |(irqStat & irqMask);
        end
    end

    // =====================================================================
    // read path and acknowledge
    // =====================================================================
    logic [DAT_W-1:0] next_datO;

    always_comb begin
        next_datO = '0;
        unique case (regIdx)
            IDX_CTRL2: next_datO[7:0] = ctrl2;
            IDX_READBACK: begin
                next_datO[RB_VOUT] = vsyncOut;
                next_datO[RB_HOUT] = hsyncOut;
                next_datO[RB_VIN] = vsyncS;
                next_datO[RB_HIN] = hsyncS;
            end
            IDX_MODE: begin
                next_datO[MODE_VOS] = vertical_output_select;
                next_datO[MODE_CNT_LSB +: 5] = udCnt;
            end
            IDX_IRQ_STAT: next_datO[IRQ_W-1:0] = irqStat;
            IDX_IRQ_MASK: next_datO[IRQ_W-1:0] = irqMask;
            default: next_datO = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= busReq && !ack_o;
            if (busReq && !ack_o && !we_i) begin
                dat_o <= next_datO;
            end
        end
    end

    // =====================================================================
    // checks
    // =====================================================================
    property p_out_off;
        @(posedge clk_sys) disable iff (!rst_n)
        ctrl2[CTRL2_OUT_OFF] |=> !hsyncOut && !vsyncOut;
    endproperty
    a_out_off: assert property (p_out_off) else $error("sync outputs not forced low");

    property p_count_up;
        @(posedge clk_sys) disable iff (!rst_n)
        tick && csyncS && udCnt != CNT_FULL |=> udCnt == $past(udCnt) + 5'h01;
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter failed to count up");

    property p_count_down_sat;
        @(posedge clk_sys) disable iff (!rst_n)
        tick && !csyncS && udCnt == CNT_ZERO |=> udCnt == CNT_ZERO;
    endproperty
    a_count_down_sat: assert property (p_count_down_sat) else $error("counter underflowed");

    property p_sep_high;
        @(posedge clk_sys) disable iff (!rst_n)
        udCnt == CNT_FULL ##1 ctrl2[CTRL2_PSEUDO_OFF] && !ctrl2[CTRL2_OUT_OFF] && vertical_output_select
            |=> vsyncOut;
    endproperty
    a_sep_high: assert property (p_sep_high) else $error("separated sync not high");

    property p_latch_flag;
        @(posedge clk_sys) disable iff (!rst_n)
        $changed(sepVsync) |=> ctrl2[CTRL2_LATCH_CHG];
    endproperty
    a_latch_flag: assert property (p_latch_flag) else $error("latch change not flagged");

    property p_div3;
        @(posedge clk_sys) disable iff (!rst_n)
        tick && !ctrl2[CTRL2_CLKSEL] ##1 !ctrl2[CTRL2_CLKSEL] |-> !tick ##1 !tick;
    endproperty
    a_div3: assert property (p_div3) else $error("divide by three spacing wrong");

    property p_sog_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        sogClear |=> sogCnt == 6'h00;
    endproperty
    a_sog_clear: assert property (p_sog_clear) else $error("sog counter not cleared");

    property p_sog_64;
        @(posedge clk_sys) disable iff (!rst_n)
        sogEdge && !sogFound && sogCnt == SOG_CNT_LAST |=> sogFound;
    endproperty
    a_sog_64: assert property (p_sog_64) else $error("sog not found on 64th edge");

    property p_bit6_zero;
        @(posedge clk_sys) disable iff (!rst_n)
        ack_o && !we_i && regIdx == IDX_CTRL2 |-> !dat_o[CTRL2_UNUSED];
    endproperty
    a_bit6_zero: assert property (p_bit6_zero) else $error("unused bit reads one");

    property p_level;
        @(posedge clk_sys) disable iff (!rst_n)
        wrLane0 && regIdx == IDX_CTRL2 |=> ##1 levelSel3v3 == $past(dat_i[CTRL2_LEVEL], 2);
    endproperty
    a_level: assert property (p_level) else $error("level select mismatch");

    property p_unmixed_off;
        @(posedge clk_sys) disable iff (!rst_n)
        !vertical_output_select ##1 !vertical_output_select |=> !ctrl2[CTRL2_UNMIXED];
    endproperty
    a_unmixed_off: assert property (p_unmixed_off) else $error("unmixed set without vos");

    property p_pseudo;
        @(posedge clk_sys) disable iff (!rst_n)
        !ctrl2[CTRL2_PSEUDO_OFF] && !ctrl2[CTRL2_OUT_OFF] |=> hsyncOut == $past(pseudoH);
    endproperty
    a_pseudo: assert property (p_pseudo) else $error("pseudo hsync not driven");

    property p_readback;
        @(posedge clk_sys) disable iff (!rst_n)
        busReq && !ack_o && !we_i && regIdx == IDX_READBACK
            |=> dat_o[RB_HOUT] == $past(hsyncOut) && dat_o[RB_VIN] == $past(vsyncS);
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");

endmodule

// ===== verif/sync_source_model.sv
// video source model: drives the horizontal, vertical and composite sync pins
// assumes the bench commands levels and bursts of composite edges on clk_sys edges
`timescale 1ns/10ps
module sync_source_model (
    input wire logic clk_sys,
    input wire logic hLevel,
    input wire logic vLevel,
    input wire logic csLoad,
    input wire logic csVal,
    input wire logic edgeGo,
    input wire logic [7:0] edgeCount,
    output logic hsyncIn,
    output logic vsyncIn,
    output logic csyncIn,
    output logic busy
);
    logic [7:0] left;
    logic [1:0] gap;

    // =====================================================================
    // pin drive
    // =====================================================================
    always_ff @(posedge clk_sys) begin
        hsyncIn <= hLevel;
        vsyncIn <= vLevel;
    end

    // edges spaced four clocks so every one survives the synchronizer
    // load and burst are separate so both can be primed while reset holds
    always_ff @(posedge clk_sys) begin
        if (csLoad) begin
            csyncIn <= csVal;
        end
        if (edgeGo) begin
            left <= edgeCount;
            gap <= 2'h0;
        end else if (left != 8'h00) begin
            gap <= gap + 2'h1;
            if (gap == 2'h3) begin
                csyncIn <= ~csyncIn;
                left <= left - 8'h01;
            end
        end
    end

    assign busy = (left != 8'h00);
endmodule

// ===== verif/tb_monitor_sync_processor_control.sv
// self-checking bench for the monitor sync processor control block
// assumes the sync source model on the pins and a classic wishbone master here
`timescale 1ns/10ps
module tb_monitor_sync_processor_control;
    import sync_proc_pkg::*;
    logic clk_sys, rst_n, cyc, stb, we, hLevel, vLevel, csLoad, csVal, edgeGo, busy;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [DAT_W-1:0] wdat, dat_o;
    logic [31:0] rdat;
    logic [7:0] edgeCount;
    logic ack_o, hsyncIn, vsyncIn, csyncIn, hsyncOut, vsyncOut, levelSel3v3, irq;
    logic [3:0] pinVec;
    int n_fail, num_checks;

    assign pinVec = {irq, levelSel3v3, vsyncOut, hsyncOut};

    monitor_sync_processor_control i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
        .ack_o(ack_o), .hsyncIn(hsyncIn), .vsyncIn(vsyncIn), .csyncIn(csyncIn),
        .hsyncOut(hsyncOut), .vsyncOut(vsyncOut), .levelSel3v3(levelSel3v3), .irq(irq));

    sync_source_model i_src (.clk_sys(clk_sys), .hLevel(hLevel), .vLevel(vLevel),
        .csLoad(csLoad), .csVal(csVal), .edgeGo(edgeGo), .edgeCount(edgeCount),
        .hsyncIn(hsyncIn), .vsyncIn(vsyncIn), .csyncIn(csyncIn), .busy(busy));

    // =====================================================================
    // shared tasks
    // =====================================================================
    task automatic results();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one classic cycle; read data taken at the edge where ack is seen
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h1;
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) check(32'h0000dead, 32'h00000000);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, idx, 8'h00);
        check(rdat & m, e);
    endtask

    // pins are looked at mid-cycle, away from the launching edge
    task automatic pins(input logic [3:0] m, input logic [3:0] e);
        @(negedge clk_sys);
        check({28'h0, pinVec & m}, {28'h0, e});
        @(posedge clk_sys);
    endtask

    task automatic cs(input logic v);
        csLoad <= 1'b1;
        csVal <= v;
        @(posedge clk_sys);
        csLoad <= 1'b0;
    endtask

    task automatic edges(input logic [7:0] n);
        int k;
        k = 0;
        edgeCount <= n;
        edgeGo <= 1'b1;
        @(posedge clk_sys);
        edgeGo <= 1'b0;
        @(posedge clk_sys);
        while (busy === 1'b1 && k < 2000) begin
            @(posedge clk_sys);
            k++;
        end
        check({31'h0, busy}, 32'h0);
        tick(6);
    endtask

    // =====================================================================
    // scenarios
    // =====================================================================
    task automatic tRegs();
        rd(IDX_CTRL2, 32'hffffffff, 32'h0);
        rd(IDX_IRQ_MASK, 32'h7, 32'h0);
        wb(1'b1, IDX_CTRL2, 8'h79);
        rd(IDX_CTRL2, 32'h79, 32'h39);
        pins(4'h4, 4'h4);
        wb(1'b1, IDX_CTRL2, 8'h38);
        pins(4'h4, 4'h0);
        rd(8'h10, 32'hffffffff, 32'h0);
        $display("done: registers");
    endtask

    task automatic tOut();
        hLevel <= 1'b1;
        vLevel <= 1'b1;
        wb(1'b1, IDX_CTRL2, 8'h18);
        tick(6);
        pins(4'h3, 4'h0);
        wb(1'b1, IDX_CTRL2, 8'h10);
        tick(6);
        pins(4'h3, 4'h3);
        rd(IDX_READBACK, 32'hff, 32'h0f);
        hLevel <= 1'b0;
        tick(6);
        rd(IDX_READBACK, 32'hff, 32'h0a);
        vLevel <= 1'b0;
        $display("done: outputs and readback");
    endtask

    task automatic tPseudo();
        int cnt;
        cnt = 0;
        wb(1'b1, IDX_CTRL2, 8'h00);
        tick(10);
        repeat (2 * PSEUDO_H_PERIOD_CYC) begin
            @(negedge clk_sys);
            if (hsyncOut === 1'b1) cnt++;
        end
        @(posedge clk_sys);
        check(cnt, 32'(2 * PSEUDO_H_WIDTH_CYC));
        $display("done: pseudo sync");
    endtask

    task automatic tCounter(input logic fast);
        int n, d;
        n = 0;
        d = fast ? 2 : 3;
        wb(1'b1, IDX_MODE, 8'h01);
        wb(1'b1, IDX_CTRL2, {2'b00, fast, 5'h10});
        cs(1'b0);
        tick(120);
        wb(1'b1, IDX_IRQ_STAT, 8'h07);
        cs(1'b1);
        while (vsyncOut !== 1'b1 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
        check(n >= 31 * d && n <= 31 * d + 8, 32'h1);
        tick(80);
        rd(IDX_MODE, 32'h1f00, 32'h1f00);
        rd(IDX_CTRL2, 32'h02, 32'h02);
        rd(IDX_IRQ_STAT, 32'h5, 32'h5);
        wb(1'b1, IDX_CTRL2, {2'b00, fast, 5'h10});
        rd(IDX_CTRL2, 32'h02, 32'h00);
        cs(1'b0);
        tick(120);
        rd(IDX_MODE, 32'h1f00, 32'h0);
        pins(4'h2, 4'h0);
        $display("done: counter");
    endtask

    task automatic tSog();
        wb(1'b1, IDX_CTRL2, 8'h30);
        wb(1'b1, IDX_IRQ_MASK, 8'h02);
        wb(1'b1, IDX_IRQ_STAT, 8'h07);
        edges(8'h3f);
        rd(IDX_CTRL2, 32'h04, 32'h0);
        pins(4'h8, 4'h0);
        edges(8'h01);
        rd(IDX_CTRL2, 32'h84, 32'h84);
        pins(4'h8, 4'h8);
        wb(1'b1, IDX_IRQ_STAT, 8'h02);
        tick(2);
        pins(4'h8, 4'h0);
        wb(1'b1, IDX_CTRL2, 8'h30);
        rd(IDX_CTRL2, 32'h04, 32'h0);
        $display("done: sync on green and interrupt");
    endtask

    // =====================================================================
    // clock, reset, sequence, watchdog
    // =====================================================================
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        rst_n = 1'b0;
        {cyc, stb, we, hLevel, vLevel, csLoad, csVal, edgeGo} = 8'h05;
        adr = '0;
        sel = 4'h0;
        wdat = '0;
        edgeCount = 8'h00;
        n_fail = 0;
        num_checks = 0;
        tick(6);
        rst_n <= 1'b1;
        csLoad <= 1'b0;
        edgeGo <= 1'b0;
        tick(1);
        tRegs();
        tOut();
        tPseudo();
        tCounter(1'b0);
        tCounter(1'b1);
        tSog();
        results();
    end

    // whole run needs well under 10000 cycles
    initial begin
        #1000000;
        n_fail++;
        results();
    end
endmodule
